/* File: core/drt_pkg.sv */
`default_nettype none
package drt_pkg;
	// =====================================================
	// clock and sample timing
	localparam int CLK_HZ = 20_000_000; // system clock rate
	localparam int RATE_MAX_HZ = 3200; // fastest sample rate
	localparam int SAMPLE_DIV_3200 = CLK_HZ / RATE_MAX_HZ; // clocks per fastest sample
	localparam int REC_SAMPLES = 2048; // samples per record at every rate
	localparam logic [6:0] MAX_RECORDS = 7'h7f; // stored record limit
	localparam logic [12:0] DUR_400_MS = 13'h1400; // record length at slowest rate
	// =====================================================
	// reset values and limits
	localparam logic [1:0] RATE_RESET = 2'h2; // 1600 samples per second
	localparam logic [6:0] PRE_RESET_PCT = 7'h19; // pre-trigger share
	localparam logic [6:0] PRE_MAX_PCT = 7'h64; // whole record
	localparam logic [17:0] PCT_DIVISOR = 18'h00064; // percent scale
	// =====================================================
	// register byte offsets
	localparam logic [7:0] REG_CTRL = 8'h00; // rate, pretrigger, trip and pickup enables
	localparam logic [7:0] REG_DO_EN = 8'h04; // output trigger enables
	localparam logic [7:0] REG_DI_EN = 8'h08; // input trigger enables
	localparam logic [7:0] REG_DI_POL = 8'h0c; // input polarity, 1 inverts
	localparam logic [7:0] REG_STATUS = 8'h10; // count, full, state, duration
	localparam logic [7:0] REG_CAUSE = 8'h14; // sources of the last trigger
	localparam logic [7:0] REG_FUNC_EN = 8'h18; // enabled function mask
	// =====================================================
	// field positions
	localparam int CTRL_RATE_LSB = 0; // two bits
	localparam int CTRL_TRIP_BIT = 2;
	localparam int CTRL_PICK_BIT = 3;
	localparam int CTRL_PRE_LSB = 8; // seven bits
	localparam int CTRL_CLR_BIT = 31; // write one clears stored records
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	// =====================================================
	// types
	typedef enum logic [1:0] {
		DRT_FILL = 2'b00, // gathering pre-trigger samples
		DRT_ARMED = 2'b01, // waiting for a trigger
		DRT_POST = 2'b11, // capturing after the trigger
		DRT_CLOSE = 2'b10 // closing the record
	} drt_state_t;
	typedef struct packed {
		logic [3:0][15:0] analog; // four measurement channels
		logic [15:0] func; // enabled function signals
		logic [7:0] dout; // output activation, active high
		logic [9:0] din; // discrete inputs, active high
		logic trip; // any trip
		logic pickup; // any pickup
	} drt_sample_t;
	typedef struct packed {
		logic wr; // one-cycle write strobe
		logic [6:0] slot; // record slot
		logic [10:0] addr; // ring position in slot
		drt_sample_t data;
	} drt_store_t;
	typedef struct packed {
		logic done; // one-cycle record complete
		logic [6:0] slot;
		logic [10:0] first_addr; // oldest sample of the record
		logic [10:0] trig_addr; // sample at trigger instant
		logic [1:0] rate; // rate the record was taken at
	} drt_close_t;
endpackage
`default_nettype wire

/* File: core/drt_din_sync.sv */
`default_nettype none
module drt_din_sync (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic [9:0] discrete_input_line,
	input wire logic [9:0] polarity,
	output logic [9:0] level
);
	// =====================================================
	// three-stage synchroniser with agreement filter
	typedef struct packed {
		logic [9:0] s1; // metastable stage, read only by s2
		logic [9:0] s2;
		logic [9:0] s3;
		logic [9:0] level; // filtered, active-high level
	} drt_sync_t;
	drt_sync_t st;
	drt_sync_t next_st;

	// next state: a change counts once s2 and s3 agree
	always_comb begin
		next_st = st;
		next_st.s1 = discrete_input_line;
		next_st.s2 = st.s1;
		next_st.s3 = st.s2;
		for (int i = 0; i < 10; i++) begin
			if (st.s2[i] == st.s3[i]) begin
				next_st.level[i] = st.s2[i] ^ polarity[i]; // [R10]
			end
		end
	end

	// registered state
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

	assign level = st.level;
endmodule
`default_nettype wire

/* File: core/drt_recorder.sv */
// Summary of operation
// [R1] sample rate 400/800/1600/3200, default 1600
// [R2] duration follows rate, read only
// [R3] pretrigger share 0..100 percent, default 25
// [R4] trip enable starts recording, default off
// [R5] pickup enable starts recording, default off
// [R6] eight output trigger enables
// [R7] ten input trigger enables
// [R8] at most 127 records, time ordered
// [R9] record holds analog channels and binary signals
// [R10] stored input and output states active high
// [R11] OR triggers, ring pretrigger, capture full length
//
// Added by the designer: the AXI4-Lite slave port and the placing of the registers.
`default_nettype none
module drt_recorder #(
	parameter int SAMPLE_DIV = drt_pkg::SAMPLE_DIV_3200
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic [15:0] trip_sig,
	input wire logic [15:0] pickup_sig,
	input wire logic [15:0] func_sig,
	input wire logic [7:0] dout_drive,
	input wire logic [9:0] discrete_input_line,
	input wire logic [3:0][15:0] analog_ch,
	output drt_pkg::drt_store_t rec_store,
	output drt_pkg::drt_close_t rec_close
);
	// =====================================================
	// state
	typedef drt_pkg::drt_state_t drt_state_t;
	typedef struct packed {
		logic aw_ok; // write address held
		logic [7:0] aw_addr;
		logic w_ok; // write data held
		logic [31:0] wdata;
		logic [3:0] wstrb;
		logic bvalid;
		logic [1:0] bresp;
		logic rvalid;
		logic [31:0] rdata;
		logic [1:0] rresp;
		logic [1:0] rate; // sample rate select
		logic trip_en;
		logic pick_en;
		logic [6:0] pre_pct; // pretrigger percent
		logic [7:0] do_en;
		logic [9:0] di_en;
		logic [9:0] di_pol;
		logic [15:0] func_en;
		logic [15:0] div_cnt; // fastest-rate divider
		logic [2:0] sub; // slower-rate subdivider
		logic prev_trip;
		logic prev_pick;
		logic [7:0] prev_do;
		logic [9:0] prev_di;
		logic [19:0] pend; // triggers seen since last sample
		logic [19:0] last_cause;
		drt_state_t fsm;
		logic [10:0] wr_addr; // ring write position
		logic [11:0] fill; // samples held before trigger
		logic [11:0] post_left; // samples still to capture
		logic [11:0] rec_pre; // pretrigger samples of this record
		logic [10:0] trig_addr;
		logic [6:0] count; // stored records
		drt_pkg::drt_store_t store;
		drt_pkg::drt_close_t close;
	} drt_reg_t;
	drt_reg_t st;
	drt_reg_t next_st;

	// =====================================================
	// discrete inputs from pins
	logic [9:0] din_level; // synchronised, active high

	drt_din_sync u_sync (
		.clk(clk),
		.rst_n(rst_n),
		.discrete_input_line(discrete_input_line),
		.polarity(st.di_pol),
		.level(din_level)
	);

	// =====================================================
	// combinational helpers
	logic trip_any; // any trip present
	logic pick_any; // any pickup present
	logic [19:0] cause_now; // rising edges of enabled sources
	logic [19:0] cause_all; // pending plus current
	logic tick3200; // fastest-rate enable
	logic sample_tick; // selected-rate enable
	logic [17:0] pre_prod;
	logic [11:0] pre_n; // pretrigger samples from percent
	logic [11:0] post_n; // samples from trigger to end
	logic full; // record store exhausted
	logic trig; // accepted trigger at this sample
	logic [12:0] dur_ms; // reported duration
	logic [31:0] wmerged; // write data merged by strobes
	logic [31:0] rd_val;
	logic rd_hit;
	logic wr_hit;
	drt_pkg::drt_sample_t smp;

	// byte-lane merge for partial writes
	function automatic logic [31:0] drt_merge(input logic [31:0] old, input logic [31:0] nw,
			input logic [3:0] strb);
		logic [31:0] res;
		res = old;
		for (int b = 0; b < 4; b++) begin
			if (strb[b]) begin
				res[b*8 +: 8] = nw[b*8 +: 8];
			end
		end
		return res;
	endfunction

	// trigger sources, sample timing and data word
	always_comb begin
		trip_any = |trip_sig;
		pick_any = |pickup_sig;
		// edge-sensitive: a standing signal starts one record only
		cause_now = {st.di_en & din_level & ~st.prev_di, // [R7]
			st.do_en & dout_drive & ~st.prev_do, // [R6]
			st.pick_en & pick_any & ~st.prev_pick, // [R5]
			st.trip_en & trip_any & ~st.prev_trip}; // [R4]
		cause_all = st.pend | cause_now; // [R11]
		tick3200 = (st.div_cnt == 16'(SAMPLE_DIV - 1));
		sample_tick = tick3200 && ((st.sub & (3'h7 >> st.rate)) == 3'h0); // [R1]
		pre_prod = {st.pre_pct, 11'h000};
		pre_n = 12'(pre_prod / drt_pkg::PCT_DIVISOR); // [R3]
		post_n = 12'(drt_pkg::REC_SAMPLES) - pre_n;
		full = (st.count == drt_pkg::MAX_RECORDS); // [R8]
		trig = sample_tick && (|cause_all) && (st.fsm == drt_pkg::DRT_ARMED) && !full;
		dur_ms = drt_pkg::DUR_400_MS >> st.rate; // [R2]
		smp.analog = analog_ch; // [R9]
		smp.func = func_sig & st.func_en;
		smp.dout = dout_drive;
		smp.din = din_level; // [R10]
		smp.trip = trip_any;
		smp.pickup = pick_any;
	end

	// register read decode
	always_comb begin
		rd_hit = 1'b1;
		rd_val = 32'h0;
		case (s_axi_araddr)
			drt_pkg::REG_CTRL: begin
				rd_val = {17'h0, st.pre_pct, 4'h0, st.pick_en, st.trip_en, st.rate};
			end
			drt_pkg::REG_DO_EN: begin
				rd_val = {24'h0, st.do_en};
			end
			drt_pkg::REG_DI_EN: begin
				rd_val = {22'h0, st.di_en};
			end
			drt_pkg::REG_DI_POL: begin
				rd_val = {22'h0, st.di_pol};
			end
			drt_pkg::REG_STATUS: begin
				rd_val = {3'h0, dur_ms, 6'h0, st.fsm, full, st.count};
			end
			drt_pkg::REG_CAUSE: begin
				rd_val = {12'h0, st.last_cause};
			end
			drt_pkg::REG_FUNC_EN: begin
				rd_val = {16'h0, st.func_en};
			end
			default: begin
				rd_hit = 1'b0; // unmapped answers slave error
			end
		endcase
	end

	// =====================================================
	// next-state logic
	always_comb begin
		next_st = st;
		wr_hit = 1'b1;
		wmerged = 32'h0;
		next_st.store.wr = 1'b0;
		next_st.close.done = 1'b0;
		// bus write: address and data taken in either order
		if (s_axi_awvalid && s_axi_awready) begin
			next_st.aw_ok = 1'b1;
			next_st.aw_addr = s_axi_awaddr;
		end
		if (s_axi_wvalid && s_axi_wready) begin
			next_st.w_ok = 1'b1;
			next_st.wdata = s_axi_wdata;
			next_st.wstrb = s_axi_wstrb;
		end
		if (st.bvalid && s_axi_bready) begin
			next_st.bvalid = 1'b0;
		end
		// register write commit and record clear; a record closing this cycle still counts
		if (st.aw_ok && st.w_ok && !st.bvalid) begin
			next_st.aw_ok = 1'b0;
			next_st.w_ok = 1'b0;
			next_st.bvalid = 1'b1;
			case (st.aw_addr)
				drt_pkg::REG_CTRL: begin
					wmerged = drt_merge({17'h0, st.pre_pct, 4'h0, st.pick_en, st.trip_en,
						st.rate}, st.wdata, st.wstrb);
					next_st.rate = wmerged[drt_pkg::CTRL_RATE_LSB +: 2]; // [R1]
					next_st.trip_en = wmerged[drt_pkg::CTRL_TRIP_BIT]; // [R4]
					next_st.pick_en = wmerged[drt_pkg::CTRL_PICK_BIT]; // [R5]
					// out-of-range percent is held at the whole record
					if (wmerged[drt_pkg::CTRL_PRE_LSB +: 7] > drt_pkg::PRE_MAX_PCT) begin
						next_st.pre_pct = drt_pkg::PRE_MAX_PCT; // [R3]
					end else begin
						next_st.pre_pct = wmerged[drt_pkg::CTRL_PRE_LSB +: 7];
					end
					if (st.wstrb[3] && st.wdata[drt_pkg::CTRL_CLR_BIT]) begin
						next_st.count = 7'h0;
					end
				end
				drt_pkg::REG_DO_EN: begin
					wmerged = drt_merge({24'h0, st.do_en}, st.wdata, st.wstrb);
					next_st.do_en = wmerged[7:0]; // [R6]
				end
				drt_pkg::REG_DI_EN: begin
					wmerged = drt_merge({22'h0, st.di_en}, st.wdata, st.wstrb);
					next_st.di_en = wmerged[9:0]; // [R7]
				end
				drt_pkg::REG_DI_POL: begin
					wmerged = drt_merge({22'h0, st.di_pol}, st.wdata, st.wstrb);
					next_st.di_pol = wmerged[9:0];
				end
				drt_pkg::REG_FUNC_EN: begin
					wmerged = drt_merge({16'h0, st.func_en}, st.wdata, st.wstrb);
					next_st.func_en = wmerged[15:0];
				end
				drt_pkg::REG_STATUS, drt_pkg::REG_CAUSE: begin
					wr_hit = 1'b1; // read-only, write ignored
				end
				default: begin
					wr_hit = 1'b0;
				end
			endcase
			next_st.bresp = wr_hit ? drt_pkg::RESP_OKAY : drt_pkg::RESP_SLVERR;
		end
		// bus read: data registered at the address handshake
		if (s_axi_arvalid && s_axi_arready) begin
			next_st.rvalid = 1'b1;
			next_st.rdata = rd_val;
			next_st.rresp = rd_hit ? drt_pkg::RESP_OKAY : drt_pkg::RESP_SLVERR;
		end else if (st.rvalid && s_axi_rready) begin
			next_st.rvalid = 1'b0;
		end
		// sample-rate divider
		if (tick3200) begin
			next_st.div_cnt = 16'h0;
			next_st.sub = st.sub + 3'h1;
		end else begin
			next_st.div_cnt = st.div_cnt + 16'h1;
		end
		// source history for edge detection
		next_st.prev_trip = trip_any;
		next_st.prev_pick = pick_any;
		next_st.prev_do = dout_drive;
		next_st.prev_di = din_level;
		// triggers between samples wait for the next sample
		next_st.pend = sample_tick ? 20'h0 : cause_all; // [R11]
		// capture sequence
		case (st.fsm)
			drt_pkg::DRT_FILL, drt_pkg::DRT_ARMED: begin
				if (trig) begin
					next_st.trig_addr = st.wr_addr;
					next_st.last_cause = cause_all;
					next_st.rec_pre = pre_n;
					if (post_n == 12'h0) begin
						next_st.fsm = drt_pkg::DRT_CLOSE; // all pre-trigger, nothing more
					end else begin
						next_st.store.wr = 1'b1;
						next_st.wr_addr = st.wr_addr + 11'h1;
						next_st.post_left = post_n - 12'h1;
						next_st.fsm = (post_n == 12'h1) ? drt_pkg::DRT_CLOSE
							: drt_pkg::DRT_POST;
					end
				end else if (sample_tick) begin
					// ring keeps overwriting the oldest pre-trigger sample
					next_st.store.wr = 1'b1; // [R11]
					next_st.wr_addr = st.wr_addr + 11'h1;
					if (st.fill < 12'(drt_pkg::REC_SAMPLES)) begin
						next_st.fill = st.fill + 12'h1;
					end
				end
				// arm only once the pretrigger share is in the ring
				if (!trig) begin
					next_st.fsm = (st.fill >= pre_n) ? drt_pkg::DRT_ARMED
						: drt_pkg::DRT_FILL;
				end
			end
			drt_pkg::DRT_POST: begin
				if (sample_tick) begin
					next_st.store.wr = 1'b1; // [R11]
					next_st.wr_addr = st.wr_addr + 11'h1;
					next_st.post_left = st.post_left - 12'h1;
					if (st.post_left == 12'h1) begin
						next_st.fsm = drt_pkg::DRT_CLOSE;
					end
				end
			end
			drt_pkg::DRT_CLOSE: begin
				next_st.close.done = 1'b1; // [R8]
				next_st.close.slot = st.count;
				next_st.close.trig_addr = st.trig_addr;
				next_st.close.first_addr = st.trig_addr - st.rec_pre[10:0];
				next_st.close.rate = st.rate;
				next_st.count = next_st.count + 7'h1; // added after a same-cycle clear
				next_st.fill = 12'h0;
				next_st.wr_addr = 11'h0;
				next_st.fsm = drt_pkg::DRT_FILL;
			end
			default: begin
				next_st.fsm = drt_pkg::DRT_FILL;
			end
		endcase
		if (next_st.store.wr) begin
			next_st.store.slot = st.count; // slots follow trigger order
			next_st.store.addr = st.wr_addr;
			next_st.store.data = smp;
		end
	end

	// =====================================================
	// registered state
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			st <= '0;
			st.rate <= drt_pkg::RATE_RESET;
			st.pre_pct <= drt_pkg::PRE_RESET_PCT;
			st.func_en <= 16'hffff;
			st.fsm <= drt_pkg::DRT_FILL;
		end else begin
			st <= next_st;
		end
	end

	// =====================================================
	// outputs
	assign s_axi_awready = !st.aw_ok && !st.bvalid;
	assign s_axi_wready = !st.w_ok && !st.bvalid;
	assign s_axi_bvalid = st.bvalid;
	assign s_axi_bresp = st.bresp;
	assign s_axi_arready = !st.rvalid;
	assign s_axi_rvalid = st.rvalid;
	assign s_axi_rdata = st.rdata;
	assign s_axi_rresp = st.rresp;
	assign rec_store = st.store;
	assign rec_close = st.close;
endmodule
`default_nettype wire

/* File: verification/drt_monitor.sv */
`default_nettype none
module drt_monitor #(
	parameter int SAMPLE_DIV = drt_pkg::SAMPLE_DIV_3200
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic s_axi_rvalid,
	input wire drt_pkg::drt_store_t rec_store,
	input wire drt_pkg::drt_close_t rec_close
);
	timeunit 1ns;
	timeprecision 1ns;
	// ====
	// helper state
	logic [7:0] rd_addr; // address of the read in flight
	logic [10:0] last_addr; // ring slot of the previous store
	logic seen; // a store happened since reset
	// remember what was asked and where the ring stood
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			seen <= 1'b0;
		end else if (rec_store.wr) begin
			seen <= 1'b1;
		end
		if (rec_store.wr) begin
			last_addr <= rec_store.addr;
		end
		if (s_axi_arvalid && s_axi_arready) begin
			rd_addr <= s_axi_araddr;
		end
	end
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);
	// ====
	// checks; sample spacing assumes SAMPLE_DIV of eight or more
	chk_store_spacing: assert property (rec_store.wr |=> !rec_store.wr [*7])
		else $error("store strobes closer than eight clocks");
	chk_done_single: assert property (rec_close.done |=> !rec_close.done)
		else $error("close strobe longer than one clock");
	// a whole-record pretrigger closes on the trigger tick with no store
	chk_done_order: assert property (rec_close.done |-> $past(rec_store.wr)
		|| (rec_close.first_addr == rec_close.trig_addr
		&& rec_close.trig_addr == last_addr + 11'h001))
		else $error("record closed without a final store");
	chk_ring_step: assert property (rec_store.wr && seen |->
		rec_store.addr == last_addr + 11'h001 || rec_store.addr == 11'h000)
		else $error("ring position skipped");
	chk_status_dur: assert property (s_axi_rvalid && rd_addr == drt_pkg::REG_STATUS |->
		s_axi_rdata[28:16] inside {13'h1400, 13'h0a00, 13'h0500, 13'h0280})
		else $error("reported duration not a legal length");
	chk_full_flag: assert property (s_axi_rvalid && rd_addr == drt_pkg::REG_STATUS |->
		s_axi_rdata[7] == (s_axi_rdata[6:0] == drt_pkg::MAX_RECORDS))
		else $error("full flag disagrees with count");
	chk_pre_limit: assert property (s_axi_rvalid && rd_addr == drt_pkg::REG_CTRL |->
		s_axi_rdata[14:8] <= drt_pkg::PRE_MAX_PCT && !s_axi_rdata[31])
		else $error("pretrigger share above full record");
	chk_cause_width: assert property (s_axi_rvalid && rd_addr == drt_pkg::REG_CAUSE |->
		s_axi_rdata[31:20] == 12'h000)
		else $error("cause reports a source that does not exist");
endmodule
bind drt_recorder drt_monitor #(.SAMPLE_DIV(SAMPLE_DIV)) mon (.clk, .rst_n, .s_axi_araddr,
	.s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .rec_store, .rec_close);
`default_nettype wire

/* File: verification/drt_source_model.sv */
`default_nettype none
module drt_source_model (
	input wire logic clk,
	input wire logic trip_on,
	input wire logic pick_on,
	input wire logic [7:0] dout_on,
	input wire logic [9:0] din_on,
	output logic [15:0] trip_sig,
	output logic [15:0] pickup_sig,
	output logic [15:0] func_sig,
	output logic [7:0] dout_drive,
	output logic [9:0] discrete_input_line,
	output logic [3:0][15:0] analog_ch
);
	timeunit 1ns;
	timeprecision 1ns;
	// ====
	// acquisition sweep
	logic [15:0] ramp = 16'h0000; // moves every clock, so a stale sample shows
	always @(posedge clk) begin
		ramp <= ramp + 16'h0001;
	end
	// one function per event, so the recorder must OR across the bus
	assign trip_sig = trip_on ? 16'h0040 : 16'h0000;
	assign pickup_sig = pick_on ? 16'h8000 : 16'h0000;
	assign func_sig = 16'hc35a; // steady function states
	assign dout_drive = dout_on;
	assign discrete_input_line = din_on; // raw pins, no debounce here
	assign analog_ch = {ramp, ~ramp, ramp ^ 16'h5a5a, 16'h7fff - ramp};
endmodule
`default_nettype wire

/* File: verification/drt_recorder_tb.sv */
`default_nettype none
module drt_recorder_tb;
	timeunit 1ns;
	timeprecision 1ns;
	// ====
	// bus and source signals, all quiet at time zero
	logic clk, rst_n = 1'b0;
	logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
	logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
	logic [3:0] s_axi_wstrb = 4'hf; // whole words only
	logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
	logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	logic [15:0] trip_sig, pickup_sig, func_sig;
	logic [7:0] dout_drive, dout_on = 8'h00;
	logic [9:0] discrete_input_line, din_on = 10'h000;
	logic [3:0][15:0] analog_ch;
	logic trip_on = 1'b0, pick_on = 1'b0;
	drt_pkg::drt_store_t rec_store;
	drt_pkg::drt_close_t rec_close;
	drt_pkg::drt_sample_t s; // last stored sample at close
	int fails = 0, checks_done = 0, n_rec = 0;
	// short divider keeps each record near sixteen thousand clocks
	drt_recorder #(.SAMPLE_DIV(8)) dut (.clk, .rst_n, .s_axi_awaddr, .s_axi_awvalid,
		.s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
		.s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
		.s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .trip_sig, .pickup_sig,
		.func_sig, .dout_drive, .discrete_input_line, .analog_ch, .rec_store, .rec_close);
	drt_source_model src (.clk, .trip_on, .pick_on, .dout_on, .din_on, .trip_sig, .pickup_sig,
		.func_sig, .dout_drive, .discrete_input_line, .analog_ch);
	// 20 MHz clock
	initial begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end
	// ====
	// shared helpers
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks_done++;
		if (got !== exp) begin
			fails++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	// one write; the leading edge keeps bready from toggling twice in a step
	// no cycle limit in the bus tasks: only the watchdog ends a stuck wait
	task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
		@(posedge clk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do begin
			@(posedge clk);
			if (s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wready) s_axi_wvalid <= 1'b0;
		end while (!s_axi_bvalid);
		s_axi_bready <= 1'b0;
		chk(s_axi_bresp, er);
	endtask
	task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		@(posedge clk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do begin
			@(posedge clk);
			if (s_axi_arready) s_axi_arvalid <= 1'b0;
		end while (!s_axi_rvalid);
		s_axi_rready <= 1'b0;
		d = s_axi_rdata;
		r = s_axi_rresp;
	endtask
	task automatic rd_chk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
		logic [31:0] d;
		logic [1:0] r;
		axi_rd(a, d, r);
		chk(d & m, e);
	endtask
	// poll until the ring has its pretrigger share and waits
	task automatic wait_armed();
		logic [31:0] d;
		logic [1:0] r;
		do begin
			axi_rd(drt_pkg::REG_STATUS, d, r);
		end while (d[9:8] !== 2'b01);
	endtask
	// one sample interval at the current rate, and the channel word it carries
	task automatic gap_chk(input int exp);
		int n;
		n = 0;
		do @(posedge clk); while (!rec_store.wr);
		// channel 0 holds 7fff minus the ramp seen one clock earlier
		chk(rec_store.data.analog[0], 16'(16'h8000 - analog_ch[3]));
		do begin
			@(posedge clk);
			n++;
		end while (!rec_store.wr);
		chk(n, exp);
	endtask
	// follow one record with no pretrigger share to its close
	task automatic capture(input logic [31:0] cause);
		logic [10:0] fa;
		int cnt;
		cnt = 0;
		fa = 11'h000;
		do begin
			@(posedge clk);
			if (rec_store.wr && cnt == 0) fa = rec_store.addr;
			if (rec_store.wr) cnt++;
		end while (!rec_close.done);
		s = rec_store.data;
		n_rec++;
		// one store may land just before the trigger sample
		chk(cnt - (fa != rec_close.trig_addr), 32'd2048);
		chk(rec_close.first_addr, rec_close.trig_addr);
		chk(rec_close.rate, 2'h3);
		chk(rec_close.slot, n_rec - 1);
		rd_chk(drt_pkg::REG_CAUSE, 32'hffffffff, cause);
		rd_chk(drt_pkg::REG_STATUS, 32'h0000007f, n_rec);
	endtask
	// ====
	// scenarios
	task automatic t_defaults();
		rd_chk(drt_pkg::REG_CTRL, 32'hffffffff, 32'h00001902);
		rd_chk(drt_pkg::REG_DO_EN, 32'hffffffff, 32'h0);
		rd_chk(drt_pkg::REG_DI_EN, 32'hffffffff, 32'h0);
		rd_chk(drt_pkg::REG_STATUS, 32'h1fff00ff, 32'h05000000);
	endtask
	// every rate, then a write to the read-only length
	task automatic t_rates();
		for (int k = 0; k < 4; k++) begin
			axi_wr(drt_pkg::REG_CTRL, k, drt_pkg::RESP_OKAY);
			rd_chk(drt_pkg::REG_CTRL, 32'h00007f03, k);
			rd_chk(drt_pkg::REG_STATUS, 32'h1fff0000,
				{3'h0, drt_pkg::DUR_400_MS >> k, 16'h0000});
			// eight clocks per fastest sample, times 3200 over the rate
			gap_chk(8 * (8 >> k));
		end
		axi_wr(drt_pkg::REG_STATUS, 32'h0, drt_pkg::RESP_OKAY);
		rd_chk(drt_pkg::REG_STATUS, 32'h1fff0000, 32'h02800000);
	endtask
	task automatic t_limits();
		logic [31:0] d;
		logic [1:0] r;
		axi_wr(drt_pkg::REG_CTRL, 32'h00007f03, drt_pkg::RESP_OKAY);
		rd_chk(drt_pkg::REG_CTRL, 32'h00007f00, 32'h00006400);
		axi_wr(drt_pkg::REG_CTRL, 32'h00000003, drt_pkg::RESP_OKAY);
		axi_wr(8'h1c, 32'hffffffff, drt_pkg::RESP_SLVERR);
		axi_rd(8'h1c, d, r);
		chk(d, 32'h0);
		chk(r, drt_pkg::RESP_SLVERR);
	endtask
	// every source fires while no enable is set
	task automatic t_masked();
		wait_armed();
		trip_on <= 1'b1;
		pick_on <= 1'b1;
		dout_on <= 8'hff;
		din_on <= 10'h3ff;
		repeat (64) @(posedge clk);
		rd_chk(drt_pkg::REG_STATUS, 32'h0000037f, 32'h00000100);
		trip_on <= 1'b0;
		pick_on <= 1'b0;
		dout_on <= 8'h00;
		din_on <= 10'h000;
	endtask
	task automatic t_trip();
		axi_wr(drt_pkg::REG_CTRL, 32'h00000007, drt_pkg::RESP_OKAY);
		wait_armed();
		trip_on <= 1'b1;
		capture(32'h00000001);
		chk(s.trip, 1'b1);
		chk(s.func, 16'hc35a);
		trip_on <= 1'b0;
	endtask
	// pickup and the top output fire together
	task automatic t_pick_out();
		axi_wr(drt_pkg::REG_CTRL, 32'h0000000b, drt_pkg::RESP_OKAY);
		axi_wr(drt_pkg::REG_DO_EN, 32'h00000080, drt_pkg::RESP_OKAY);
		wait_armed();
		pick_on <= 1'b1;
		dout_on <= 8'h80;
		capture(32'h00000202);
		chk(s.dout, 8'h80);
		pick_on <= 1'b0;
		dout_on <= 8'h00;
	endtask
	// input 1 inverted, so a low pin must be stored high
	task automatic t_input();
		axi_wr(drt_pkg::REG_CTRL, 32'h00000003, drt_pkg::RESP_OKAY);
		axi_wr(drt_pkg::REG_DI_POL, 32'h00000002, drt_pkg::RESP_OKAY);
		axi_wr(drt_pkg::REG_DI_EN, 32'h00000001, drt_pkg::RESP_OKAY);
		wait_armed();
		din_on <= 10'h001;
		capture(32'h00000400);
		chk(s.din[1:0], 2'b11);
		axi_wr(drt_pkg::REG_CTRL, 32'h80000003, drt_pkg::RESP_OKAY);
		rd_chk(drt_pkg::REG_STATUS, 32'h000000ff, 32'h0);
	endtask
	task automatic finish_test();
		$display("checks %0d errors %0d", checks_done, fails);
		if (fails == 0 && checks_done > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask
	// ====
	// main sequence
	initial begin
		repeat (12) @(posedge clk);
		rst_n <= 1'b1;
		@(posedge clk);
		t_defaults();
		t_rates();
		t_limits();
		t_masked();
		t_trip();
		t_pick_out();
		t_input();
		finish_test();
	end
	// three records take about fifty thousand clocks
	initial begin
		repeat (80000) @(posedge clk);
		fails++;
		finish_test();
	end
endmodule
`default_nettype wire
